/* File: core/capture_regs.vh */
// Register map, field positions, reset values and timing counts of the capture and trigger block.
// Assumes a 40 MHz reference clock and a 32-bit register port addressed by byte offsets, one register every four bytes.
`ifndef CAPTURE_REGS_VH
`define CAPTURE_REGS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_INTERVAL 8'h04
`define REG_HOLD 8'h08
`define REG_SEL_HI 8'h0C
`define REG_SEL_LO 8'h10
`define REG_CMD 8'h14
`define REG_CURSOR 8'h18
`define REG_STATUS 8'h1C
`define REG_READOUT 8'h20
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_CHAN_LSB 0
`define CTRL_PLACE_LSB 2
`define CTRL_ORIGIN_LSB 4
`define CTRL_SYNC_BIT 6
`define CTRL_BYTE3_BIT 7
`define CTRL_FIRST_BIT 8
`define CTRL_EXTCLK_BIT 9
`define CTRL_EXTCLK_FALL_BIT 10
`define CTRL_EXTTRIG_FALL_BIT 11
`define CTRL_RST 12'h000
`define CMD_RESET_BIT 0
`define CMD_MANUAL_BIT 1
`define HOLD_RST 16'h0000
`define SEL_RST 18'h00000
`define CURSOR_RST 10'h000
// ----------------------------------------
// Encodings and record depths
// ----------------------------------------
`define CHAN_4 2'h0
`define CHAN_8 2'h1
`define CHAN_16 2'h2
`define PLACE_CENTRE 2'h0
`define PLACE_LATE 2'h1
`define PLACE_EARLY 2'h2
`define ORIGIN_CH0 2'h0
`define ORIGIN_EXT 2'h1
`define ORIGIN_PATTERN 2'h2
`define ORIGIN_MANUAL 2'h3
`define DEPTH_4CH 10'h3F8
`define DEPTH_8CH 10'h1FC
`define DEPTH_16CH 10'h0FE
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 25
`define INTERVAL_RST_NS 1000
`define HOLD_TICK_NS 1000000
`endif

/* File: core/logic_capture_trigger.v */
// Capture, trigger and cursor readout logic of a 16-channel logic analyzer.
// Assumes probe inputs and the external clock are already synchronous to ref_clk_in.
// Summary of operation
// - Reset then manual trigger completes once armed and sampling.
// - Four-channel format keeps channels 0-3.
// - Eight-channel format keeps two nibble groups.
// - Sixteen-channel format keeps four nibble groups.
// - Four-bit readout: four groups of four.
// - Three-bit readout: four threes, one four.
// - Coarse and fine cursor select readout sample.
// - Centre placement: trigger mid record.
// - Late placement: trigger near record start.
// - Early placement: trigger near record end.
// - Hold expiry drops indicator, blanks display.
// - Channel 0 rising edge triggers, rearms.
// - High selector needs high; all match triggers.
// - Low selector needs low level.
// - Don't-care selectors leave comparison.
// - Sync matching only on external clock edges.
// - Probe qualifier joins the match.
// - External sampling: one sample per edge.
// - New format applies after record reset.
// - First-trigger mode skips fill, blanks history.
//
// The register addresses and strobed register access were chosen for this implementation.
`include "capture_regs.vh"

module logic_capture_trigger #(
  parameter TICK_CYCLES = `HOLD_TICK_NS / `CLK_PERIOD_NS // Clock cycles per hold-time tick of 1 ms.
) (
  input wire ref_clk_in,
  input wire rst_b_in,
  input wire [15:0] probe_data_in,
  input wire probe_qual_in,
  input wire ext_clock_in,
  input wire ext_trig_qual_in,
  input wire [7:0] bus_addr_in,
  input wire [31:0] bus_wdata_in,
  input wire bus_wr_in,
  input wire bus_rd_in,
  output reg [31:0] bus_rdata_out,
  output reg triggered_indicator_out,
  output wire display_valid_out,
  output reg [19:0] cursor_readout_out,
  output reg readout_blank_out,
  output wire [2:0] active_groups_out
);

  // ----------------------------------------
  // Local codes
  // ----------------------------------------
  localparam [2:0] ST_FILL = 3'h0; // Collecting history before arming.
  localparam [2:0] ST_ARMED = 3'h1; // Waiting for a trigger.
  localparam [2:0] ST_POST = 3'h2; // Collecting samples after the trigger.
  localparam [2:0] ST_DISPLAY = 3'h3; // Record frozen and presented.
  localparam [15:0] INTERVAL_RST = `INTERVAL_RST_NS / `CLK_PERIOD_NS; // 1 us sample interval.

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  reg [11:0] ctrl; // Live control settings.
  reg [15:0] interval; // Internal sample interval in clock cycles.
  reg [15:0] hold_ms; // Display hold time in ms, zero holds forever.
  reg [17:0] sel_hi; // Selectors that demand a high level.
  reg [17:0] sel_lo; // Selectors that demand a low level.
  reg [9:0] cursor; // Coarse position in [9:4], fine in [3:0].

  // ----------------------------------------
  // Acquisition state
  // ----------------------------------------
  reg [1:0] fmt_chan; // Channel format latched at record reset.
  reg [1:0] fmt_place; // Placement latched at record reset.
  reg fmt_first; // First-trigger mode latched at record reset.
  reg [2:0] state; // Acquisition state.
  reg [9:0] wp; // Next memory location to write.
  reg [9:0] start; // Oldest location of the frozen record.
  reg [9:0] cnt; // Samples counted in the current phase.
  reg [15:0] iv_cnt; // Internal interval counter.
  reg ext_clk_prev; // External clock one cycle ago.
  reg ext_trig_prev; // External trigger one cycle ago.
  reg ch0_prev; // Channel 0 at the previous sample.
  reg match_prev; // Pattern match at the previous evaluation.
  reg [31:0] tick_cnt; // Divider for the 1 ms hold tick.
  reg [15:0] hold_cnt; // Elapsed hold time in ms.

  wire cmd_wr = bus_wr_in && (bus_addr_in == `REG_CMD); // Command write.
  wire rec_reset = cmd_wr && bus_wdata_in[`CMD_RESET_BIT]; // Restart acquisition.
  wire manual_trig = cmd_wr && bus_wdata_in[`CMD_MANUAL_BIT]; // Forced trigger.

  // ----------------------------------------
  // Record geometry
  // ----------------------------------------
  // Depth per format
  wire [9:0] depth = (fmt_chan == `CHAN_4) ? `DEPTH_4CH : (fmt_chan == `CHAN_8) ? `DEPTH_8CH : `DEPTH_16CH;
  reg [9:0] post_len; // Samples kept after the trigger.
  always @* begin
    case (fmt_place)
      `PLACE_LATE: post_len = depth - (depth >> 3);
      `PLACE_EARLY: post_len = depth >> 3;
      default: post_len = depth >> 1;
    endcase
  end
  wire [9:0] trig_idx = depth - post_len; // Trigger position counted from the oldest sample.
  wire [9:0] wp_inc = wp + 10'h001;
  wire [9:0] wp_nxt = (wp_inc >= depth) ? 10'h000 : wp_inc; // Circular advance.
  assign active_groups_out = (fmt_chan == `CHAN_4) ? 3'h1 : (fmt_chan == `CHAN_8) ? 3'h2 : 3'h4;
  assign display_valid_out = (state == ST_DISPLAY);

  // ----------------------------------------
  // Sample strobe
  // ----------------------------------------
  wire ext_mode = ctrl[`CTRL_EXTCLK_BIT];
  // Active edge of the external clock, polarity chosen by software.
  wire ext_edge = ctrl[`CTRL_EXTCLK_FALL_BIT] ? (ext_clk_prev && !ext_clock_in) : (!ext_clk_prev && ext_clock_in);
  wire iv_hit = ({16'h0000, iv_cnt} + 32'h00000001) >= {16'h0000, interval}; // Interval elapsed.
  wire sample_en = ext_mode ? ext_edge : iv_hit;

  // ----------------------------------------
  // Trigger sources
  // ----------------------------------------
  wire [17:0] pat_vec = {ext_trig_qual_in, probe_qual_in, probe_data_in}; // Channels then qualifiers.
  wire match = &((~sel_hi | pat_vec) & (~sel_lo | ~pat_vec));
  wire pat_eval = ctrl[`CTRL_SYNC_BIT] ? ext_edge : 1'b1;
  wire pat_trig = pat_eval && match && !match_prev; // Moment all selected bits agree.
  wire ch0_trig = sample_en && probe_data_in[0] && !ch0_prev;
  wire ext_trig = ctrl[`CTRL_EXTTRIG_FALL_BIT] ? (ext_trig_prev && !ext_trig_qual_in) :
                  (!ext_trig_prev && ext_trig_qual_in);
  reg src_trig; // Trigger from the selected origin.
  always @* begin
    case (ctrl[`CTRL_ORIGIN_LSB +: 2])
      `ORIGIN_CH0: src_trig = ch0_trig;
      `ORIGIN_EXT: src_trig = ext_trig;
      `ORIGIN_PATTERN: src_trig = pat_trig;
      default: src_trig = 1'b0;
    endcase
  end
  wire trig_event = manual_trig || src_trig;

  // ----------------------------------------
  // Edge history registers
  // ----------------------------------------
  // Previous levels used by the edge and match detectors.
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ext_clk_prev <= 1'b0;
      ext_trig_prev <= 1'b0;
      ch0_prev <= 1'b0;
      match_prev <= 1'b1;
      iv_cnt <= 16'h0000;
    end else begin
      ext_clk_prev <= ext_clock_in;
      ext_trig_prev <= ext_trig_qual_in;
      if (sample_en) begin
        ch0_prev <= probe_data_in[0];
      end
      if (pat_eval) begin
        match_prev <= match;
      end
      // Interval counter restarts on each internal strobe.
      if (iv_hit || ext_mode) begin
        iv_cnt <= 16'h0000;
      end else begin
        iv_cnt <= iv_cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Software settings; command bits are pulses and are not stored.
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl <= `CTRL_RST;
      interval <= INTERVAL_RST;
      hold_ms <= `HOLD_RST;
      sel_hi <= `SEL_RST;
      sel_lo <= `SEL_RST;
      cursor <= `CURSOR_RST;
    end else if (bus_wr_in) begin
      case (bus_addr_in)
        `REG_CTRL: ctrl <= bus_wdata_in[11:0];
        `REG_INTERVAL: interval <= bus_wdata_in[15:0];
        `REG_HOLD: hold_ms <= bus_wdata_in[15:0];
        `REG_SEL_HI: sel_hi <= bus_wdata_in[17:0];
        `REG_SEL_LO: sel_lo <= bus_wdata_in[17:0];
        `REG_CURSOR: cursor <= bus_wdata_in[9:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Acquisition sequencer
  // ----------------------------------------
  // Moves through fill, armed, post-trigger and display, and rearms when the hold time ends.
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= ST_FILL;
      fmt_chan <= `CHAN_4;
      fmt_place <= `PLACE_CENTRE;
      fmt_first <= 1'b0;
      wp <= 10'h000;
      start <= 10'h000;
      cnt <= 10'h000;
      tick_cnt <= 32'h00000000;
      hold_cnt <= 16'h0000;
      triggered_indicator_out <= 1'b0;
    end else if (rec_reset) begin
      fmt_chan <= ctrl[`CTRL_CHAN_LSB +: 2];
      fmt_place <= ctrl[`CTRL_PLACE_LSB +: 2];
      fmt_first <= ctrl[`CTRL_FIRST_BIT];
      state <= ST_FILL;
      wp <= 10'h000;
      cnt <= 10'h000;
      triggered_indicator_out <= 1'b0;
    end else begin
      case (state)
        ST_FILL: begin
          // Gather enough history to place the trigger.
          if (sample_en) begin
            wp <= wp_nxt;
            cnt <= cnt + 10'h001;
          end
          if (fmt_first || (cnt >= trig_idx)) begin
            state <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (sample_en) begin
            wp <= wp_nxt;
          end
          if (trig_event) begin
            state <= ST_POST;
            cnt <= 10'h000;
            triggered_indicator_out <= 1'b1;
          end
        end
        ST_POST: begin
          // Fill the part of the record that follows the trigger.
          if (sample_en) begin
            wp <= wp_nxt;
            cnt <= cnt + 10'h001;
            if (cnt + 10'h001 >= post_len) begin
              state <= ST_DISPLAY;
              start <= wp_nxt;
              tick_cnt <= 32'h00000000;
              hold_cnt <= 16'h0000;
            end
          end
        end
        ST_DISPLAY: begin
          // Hold divider runs only while the record is shown.
          if (hold_ms != 16'h0000) begin
            if (tick_cnt + 32'h00000001 >= TICK_CYCLES) begin
              tick_cnt <= 32'h00000000;
              hold_cnt <= hold_cnt + 16'h0001;
              if (hold_cnt + 16'h0001 >= hold_ms) begin
                state <= ST_FILL;
                cnt <= 10'h000;
                triggered_indicator_out <= 1'b0;
              end
            end else begin
              tick_cnt <= tick_cnt + 32'h00000001;
            end
          end
        end
        default: state <= ST_FILL;
      endcase
    end
  end

  // ----------------------------------------
  // Sample memory
  // ----------------------------------------
  wire mem_we = sample_en && (state != ST_DISPLAY) && !rec_reset; // Writes stop once frozen.
  wire [9:0] w_word10 = (fmt_chan == `CHAN_4) ? (wp >> 2) : (fmt_chan == `CHAN_8) ? (wp >> 1) : wp;
  wire [7:0] w_word = w_word10[7:0]; // At most 253.

  // Cursor sample index clamped to the record.
  wire [9:0] cur_idx = (cursor >= depth) ? (depth - 10'h001) : cursor;
  wire [10:0] phys_sum = {1'b0, start} + {1'b0, cur_idx};
  wire [10:0] phys_wrap = (phys_sum >= {1'b0, depth}) ? (phys_sum - {1'b0, depth}) : phys_sum;
  wire [9:0] phys = phys_wrap[9:0]; // Memory location under the cursor.
  wire [9:0] r_word10 = (fmt_chan == `CHAN_4) ? (phys >> 2) : (fmt_chan == `CHAN_8) ? (phys >> 1) : phys;
  wire [7:0] r_word = r_word10[7:0];
  wire [15:0] rd_word; // Four nibble lanes of the addressed word.

  genvar l;
  generate
    for (l = 0; l < 4; l = l + 1) begin : g_lane
      localparam [1:0] LANE = l;
      reg [3:0] lane_mem [0:253]; // One nibble of every stored word.
      wire lane_we = mem_we && ((fmt_chan == `CHAN_16) || ((fmt_chan == `CHAN_8) && (wp[0] == LANE[1])) ||
                     ((fmt_chan == `CHAN_4) && (wp[1:0] == LANE)));
      wire [3:0] lane_wd = (fmt_chan == `CHAN_16) ? probe_data_in[4 * l +: 4] :
                           ((fmt_chan == `CHAN_8) && LANE[0]) ? probe_data_in[7:4] : probe_data_in[3:0];
      // Lane write on its own strobe.
      always @(posedge ref_clk_in) begin
        if (lane_we) begin
          lane_mem[w_word] <= lane_wd;
        end
      end
      assign rd_word[4 * l +: 4] = lane_mem[r_word];
    end
  endgenerate

  // ----------------------------------------
  // Cursor readout
  // ----------------------------------------
  reg [15:0] cur_data; // Channel states at the cursor sample, unused channels zero.
  always @* begin
    case (fmt_chan)
      `CHAN_4: cur_data = {12'h000, rd_word[{phys[1:0], 2'b00} +: 4]};
      `CHAN_8: cur_data = {8'h00, (phys[0] ? rd_word[15:8] : rd_word[7:0])};
      default: cur_data = rd_word;
    endcase
  end

  // Readout digits and blanking, refreshed every cycle.
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cursor_readout_out <= 20'h00000;
      readout_blank_out <= 1'b1;
    end else begin
      if (ctrl[`CTRL_BYTE3_BIT]) begin
        cursor_readout_out <= {cur_data[15:12], 1'b0, cur_data[11:9], 1'b0, cur_data[8:6],
                               1'b0, cur_data[5:3], 1'b0, cur_data[2:0]};
      end else begin
        cursor_readout_out <= {4'h0, cur_data};
      end
      readout_blank_out <= (state != ST_DISPLAY) || (fmt_first && (cur_idx < trig_idx));
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Read data stand in the cycle after the strobe; unmapped offsets read zero.
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus_rdata_out <= 32'h00000000;
    end else if (bus_rd_in) begin
      case (bus_addr_in)
        `REG_CTRL: bus_rdata_out <= {20'h00000, ctrl};
        `REG_INTERVAL: bus_rdata_out <= {16'h0000, interval};
        `REG_HOLD: bus_rdata_out <= {16'h0000, hold_ms};
        `REG_SEL_HI: bus_rdata_out <= {14'h0000, sel_hi};
        `REG_SEL_LO: bus_rdata_out <= {14'h0000, sel_lo};
        `REG_CURSOR: bus_rdata_out <= {22'h000000, cursor};
        `REG_STATUS: bus_rdata_out <= {12'h000, fmt_first, fmt_place, fmt_chan, display_valid_out,
                                       triggered_indicator_out, state, trig_idx};
        `REG_READOUT: bus_rdata_out <= {11'h000, readout_blank_out, cursor_readout_out};
        default: bus_rdata_out <= 32'h00000000;
      endcase
    end else begin
      bus_rdata_out <= 32'h00000000;
    end
  end

endmodule // logic_capture_trigger

/* File: verif/logic_capture_trigger_assertions.sv */
// Port-level checks of the capture and trigger block.
// Assumes one clock domain and the shared register header on the include path.
`include "capture_regs.vh"
module logic_capture_trigger_assertions #(
  parameter TICK_CYCLES = 4 // Hold tick length, handed on from the design.
) (
  input wire ref_clk_in,
  input wire rst_b_in,
  input wire [7:0] bus_addr_in,
  input wire [31:0] bus_wdata_in,
  input wire bus_wr_in,
  input wire bus_rd_in,
  input wire [31:0] bus_rdata_out,
  input wire triggered_indicator_out,
  input wire display_valid_out,
  input wire [19:0] cursor_readout_out,
  input wire readout_blank_out,
  input wire [2:0] active_groups_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // A record reset command seen on the bus.
  wire cmd_rst = bus_wr_in && bus_addr_in == `REG_CMD && bus_wdata_in[`CMD_RESET_BIT];
  // Reads of the status and readout words.
  sequence s_status_rd;
    bus_rd_in && bus_addr_in == `REG_STATUS;
  endsequence
  sequence s_readout_rd;
    bus_rd_in && bus_addr_in == `REG_READOUT;
  endsequence
  a_rdata_idle: assert property (!$past(bus_rd_in) |-> bus_rdata_out == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_status_flags: assert property (s_status_rd |=> bus_rdata_out[31:20] == 12'h000 &&
    bus_rdata_out[14:13] == {$past(display_valid_out), $past(triggered_indicator_out)})
    else $error("status flags differ from ports");
  a_groups_status: assert property (s_status_rd |=> (3'h1 << bus_rdata_out[16:15]) == $past(active_groups_out))
    else $error("group count differs from channel format");
  a_readout_word: assert property (s_readout_rd |=>
    bus_rdata_out == {11'h000, $past(readout_blank_out), $past(cursor_readout_out)})
    else $error("readout word differs from readout port");
  a_groups_on_reset: assert property ($changed(active_groups_out) |-> $past(cmd_rst) || $past(cmd_rst, 2))
    else $error("format changed without record reset");
  a_narrow_readout: assert property ((active_groups_out != 3'h4 && display_valid_out) [*3] |->
    cursor_readout_out[19:12] == 8'h00)
    else $error("disabled channels show in readout");
  a_blank_idle: assert property (!display_valid_out [*2] |-> readout_blank_out)
    else $error("readout not blank outside display");
  a_valid_after_ind: assert property ($rose(display_valid_out) |-> triggered_indicator_out)
    else $error("display without trigger indication");
  a_ind_before_post: assert property ($rose(triggered_indicator_out) |-> !display_valid_out [*2])
    else $error("trigger accepted during display");
  a_ind_drop: assert property ($fell(triggered_indicator_out) |-> !display_valid_out)
    else $error("indicator dropped while display stays");
  a_valid_drop: assert property ($fell(display_valid_out) |-> ##[0:1] !triggered_indicator_out)
    else $error("indicator stays after display ends");
endmodule // logic_capture_trigger_assertions

bind logic_capture_trigger logic_capture_trigger_assertions #(.TICK_CYCLES(TICK_CYCLES)) checker_i (.ref_clk_in,
  .rst_b_in, .bus_addr_in, .bus_wdata_in, .bus_wr_in, .bus_rd_in, .bus_rdata_out, .triggered_indicator_out,
  .display_valid_out, .cursor_readout_out, .readout_blank_out, .active_groups_out);

/* File: verif/logic_capture_trigger_tb.sv */
// Self-checking bench of the capture and trigger block with a probe source model.
// Assumes the shared register header on the include path and a 40 MHz clock.
`include "capture_regs.vh"
module logic_capture_trigger_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] level = 16'h0000;
  logic qual = 1'b0;
  logic extq = 1'b0;
  logic run = 1'b0;
  wire [15:0] probe_data;
  wire probe_qual, ext_clock, ext_trig_qual, ind, valid, blank;
  wire [31:0] rdata;
  wire [19:0] readout;
  wire [2:0] groups;
  int fail_count = 0;
  int checks = 0;
  integer seed = 32'h33576E14;
  // Pattern cases: origin, selectors, final levels and expected trigger.
  // Case 8 triggers on the falling external edge, case 9 matches only on strobe edges.
  localparam logic [1:0] PORG [10] = '{2, 2, 2, 2, 2, 2, 2, 1, 1, 2};
  localparam logic [17:0] PHI [10] = '{1, 0, 1, 18'h10008, 18'h10008, 2, 2, 0, 0, 1};
  localparam logic [17:0] PLO [10] = '{0, 18'h000FF, 0, 0, 0, 18'h20000, 18'h20000, 0, 0, 0};
  localparam logic [15:0] PDAT [10] = '{1, 0, 0, 8, 8, 2, 2, 0, 0, 1};
  localparam logic PQ [10] = '{0, 0, 0, 1, 0, 0, 0, 0, 0, 0};
  localparam logic PE [10] = '{0, 0, 0, 0, 0, 0, 1, 1, 0, 0};
  localparam logic PEX [10] = '{1, 1, 0, 1, 0, 1, 0, 1, 1, 0};
  probe_source_model probe_source_model_i (.ref_clk_in, .level_req_in(level), .qual_req_in(qual),
    .extq_req_in(extq), .strobe_run_in(run), .probe_data_out(probe_data), .probe_qual_out(probe_qual),
    .ext_clock_out(ext_clock), .ext_trig_qual_out(ext_trig_qual));
  logic_capture_trigger #(.TICK_CYCLES(4)) logic_capture_trigger_i (.ref_clk_in, .rst_b_in,
    .probe_data_in(probe_data), .probe_qual_in(probe_qual), .ext_clock_in(ext_clock),
    .ext_trig_qual_in(ext_trig_qual), .bus_addr_in(addr), .bus_wdata_in(wdata), .bus_wr_in(wr),
    .bus_rd_in(rd), .bus_rdata_out(rdata), .triggered_indicator_out(ind), .display_valid_out(valid),
    .cursor_readout_out(readout), .readout_blank_out(blank), .active_groups_out(groups));
  // Clock of 25 ns period.
  always #12.5 ref_clk_in = ~ref_clk_in;
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Waits some edges, then lets their updates settle.
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  // One-cycle register write.
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
  endtask
  // One-cycle register read; data taken in the answer cycle.
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Polls the state field with a bounded count.
  task automatic poll(input logic [2:0] st);
    logic [31:0] d;
    for (int i = 0; i < 3000; i++) begin
      rreg(`REG_STATUS, d);
      if (d[12:10] == st) return;
    end
    fail_count++;
    summarize();
  endtask
  // Waits for the display flag to reach a level, bounded.
  task automatic await(input logic lvl);
    for (int i = 0; i < 4000; i++) begin
      tick(1);
      if (valid === lvl) return;
    end
    fail_count++;
    summarize();
  endtask
  // Post-trigger sample count of a placement.
  function automatic logic [9:0] post(input logic [9:0] d, input int pl);
    return pl == 0 ? d / 2 : (pl == 1 ? d - d / 8 : d / 8);
  endfunction
  // Expected readout digits for a level word, format and grouping.
  function automatic logic [19:0] fmt(input logic [15:0] v, input int ch, input logic b3);
    logic [15:0] m;
    m = v & ~(16'hFFFF << (4 << ch));
    return b3 ? {m[15:12], 1'b0, m[11:9], 1'b0, m[8:6], 1'b0, m[5:3], 1'b0, m[2:0]} : {4'h0, m};
  endfunction
  // Main sequence.
  initial begin
    logic [31:0] d, a, b, f;
    logic [9:0] dp;
    repeat (8) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    #1;
    chk({ind, blank, groups}, 5'h09);
    for (int i = 0; i < 10; i++) begin
      if (i == 7 || i == 8) continue;
      rreg(8'(i * 4), d);
      chk(d, i == 1 ? 32'h28 : 32'h0);
    end
    a = $random(seed);
    wreg(`REG_INTERVAL, a);
    wreg(`REG_SEL_HI, a);
    rreg(`REG_INTERVAL, d);
    chk(d, a & 32'hFFFF);
    rreg(`REG_SEL_HI, d);
    chk(d, a & 32'h3FFFF);
    wreg(`REG_SEL_HI, 32'h0);
    wreg(`REG_INTERVAL, 32'h1);
    for (int ch = 0; ch < 3; ch++) begin
      for (int pl = 0; pl < 3; pl++) begin
        a = $random(seed);
        b = $random(seed);
        dp = `DEPTH_4CH >> ch;
        f = (ch == 1 && pl == 1 ? 32'h100 : 32'h0) | (pl == 2 ? 32'h80 : 32'h0);
        level <= a[15:0];
        wreg(`REG_CTRL, f | 32'h30 | pl << 2 | ch);
        wreg(`REG_CMD, 32'h1);
        poll(3'h1);
        level <= b[15:0];
        wreg(`REG_CMD, 32'h2);
        await(1'b1);
        rreg(`REG_STATUS, d);
        chk(d[9:0], dp - post(dp, pl));
        chk(d[19:13], {f[8], 2'(pl), 2'(ch), 2'h3});
        chk(groups, 3'h1 << ch);
        for (int k = 0; k < 2; k++) begin
          wreg(`REG_CURSOR, k ? 32'h3FF : 32'h0);
          tick(2);
          rreg(`REG_READOUT, d);
          if (k == 0 && f[8])
            chk(d[20], 1'b1);
          else
            chk(d[20:0], {1'b0, fmt(k ? b[15:0] : a[15:0], ch, f[7])});
        end
      end
    end
    wreg(`REG_CTRL, 32'h0);
    tick(4);
    chk(groups, 3'h4);
    wreg(`REG_HOLD, 32'h1);
    level <= 16'h0000;
    wreg(`REG_CMD, 32'h1);
    tick(4);
    chk(groups, 3'h1);
    poll(3'h1);
    tick(20);
    chk(ind, 1'b0);
    level <= 16'h0001;
    tick(4);
    chk(ind, 1'b1);
    await(1'b1);
    await(1'b0);
    tick(1);
    chk({ind, blank}, 2'h1);
    level <= 16'h0000;
    poll(3'h1);
    level <= 16'h0001;
    tick(4);
    chk(ind, 1'b1);
    for (int i = 0; i < 10; i++) begin
      d = PDAT[i] | (i == 1 ? $random(seed) & 32'hFF00 : 32'h0);
      level <= ~d[15:0];
      qual <= ~PQ[i];
      extq <= ~PE[i];
      run <= i == 9;
      wreg(`REG_SEL_HI, PHI[i]);
      wreg(`REG_SEL_LO, PLO[i]);
      wreg(`REG_CTRL, (i == 9 ? 32'h40 : 32'h0) | (i == 8 ? 32'h800 : 32'h0) | PORG[i] << 4);
      wreg(`REG_CMD, 32'h1);
      poll(3'h1);
      run <= 1'b0;
      level <= d[15:0];
      qual <= PQ[i];
      extq <= PE[i];
      tick(8);
      chk(ind, PEX[i]);
    end
    run <= 1'b1;
    tick(16);
    chk(ind, 1'b1);
    run <= 1'b0;
    // External sampling on the falling strobe edge, manual trigger only.
    wreg(`REG_CTRL, 32'h630);
    wreg(`REG_CMD, 32'h1);
    tick(100);
    rreg(`REG_STATUS, d);
    chk(d[12:10], 3'h0);
    run <= 1'b1;
    poll(3'h1);
    wreg(`REG_CMD, 32'h2);
    await(1'b1);
    chk(ind, 1'b1);
    summarize();
  end
endmodule // logic_capture_trigger_tb

/* File: verif/probe_source_model.sv */
// Model of the system under test as the probes see it.
// Assumes the bench sets requested levels; outputs change just after a clock edge.
module probe_source_model (
  input wire ref_clk_in,
  input wire [15:0] level_req_in,
  input wire qual_req_in,
  input wire extq_req_in,
  input wire strobe_run_in,
  output logic [15:0] probe_data_out = 16'h0000,
  output logic probe_qual_out = 1'b0,
  output logic ext_clock_out = 1'b0,
  output logic ext_trig_qual_out = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] div = 2'h0; // Divides the strobe to one rising edge every four cycles.
  always @(posedge ref_clk_in) begin
    probe_data_out <= level_req_in;
    probe_qual_out <= qual_req_in;
    ext_trig_qual_out <= extq_req_in;
    div <= strobe_run_in ? div + 2'h1 : 2'h0;
    // The strobe stands low whenever the bench stops it.
    ext_clock_out <= strobe_run_in & div[1];
  end
endmodule // probe_source_model
